// ==== pkg/rsq_pkg.sv ====
package rsq_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_BROWNOUT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_POWER_CONTROL_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ISTAT = 8'h0c;
  localparam logic [7:0] ADDR_IMASK = 8'h10;

  // power_control_flags fields; the event status and mask share them
  localparam int PC_OVF = 7;
  localparam int PC_UNF = 6;
  localparam int EV_WAKE = 5;
  localparam int PC_WDT = 4;
  localparam int PC_PIN = 3;
  localparam int PC_INSTR = 2;
  localparam int PC_POR = 1;
  localparam int PC_BOR = 0;

  // core_status and brownout_control fields
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int BC_SBOR = 7;
  localparam int BC_FAST = 6;
  localparam int BC_RDY = 0;

  // Flag values and masks
  localparam logic [7:0] POWER_CONTROL_FLAGS_WMASK = 8'hdf;
  localparam logic [7:0] POWER_CONTROL_FLAGS_POR_VAL = 8'h1d;
  localparam logic [7:0] POWER_CONTROL_FLAGS_BOR_KEEP = 8'h02;
  localparam logic [7:0] POWER_CONTROL_FLAGS_BOR_SET = 8'h1c;
  localparam logic SBOR_RST = 1'b1;
  localparam logic FAST_RST = 1'b0;
  localparam logic [7:0] IMASK_RST = 8'h00;

  // Program counter targets
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_IRQ = 16'h0004;

  // Timer lengths
  localparam int OST_COUNT = 1024;
  localparam int POWERUP_TIMER_COUNT = 2048;

  typedef enum logic [2:0] {
    S_HOLD = 3'b000,
    S_POWERUP_TIMER = 3'b001,
    S_OST = 3'b011,
    S_PINW = 3'b010,
    S_RUN = 3'b110
  } rsq_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rsq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsq_apb_rsp_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic low_power_brownout;
    logic pin_n;
    logic wdt;
    logic irq_wake;
    logic instr;
    logic stk_over;
    logic stk_under;
    logic sleep;
    logic osc_tick;
  } rsq_src_t;

  typedef struct packed {
    logic pin_en;
    logic powerup_timer_en;
    logic ost_req;
    logic stk_err_en;
    logic global_irq_enable;
  } rsq_cfg_t;

  typedef struct packed {
    logic crst;
    logic pc_load;
    logic [15:0] vec;
    logic resume;
    logic push;
  } rsq_core_t;

endpackage

// ==== src/rsq_timer.sv ====
`timescale 1ns/1ps
module rsq_timer
  import rsq_pkg::*;
#(
  parameter int W = 12,
  parameter int LEN = 1024
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // Control
  input wire logic start_i,
  input wire logic tick_i,
  output logic done_o
);

  if (LEN < 1 || LEN > (1 << W) - 1) begin : g_bad
    $error("rsq_timer: LEN does not fit W");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } rsq_tmr_t;

  rsq_tmr_t r;
  rsq_tmr_t next_r;

  always_comb begin
    next_r = r;
    if (start_i) begin
      next_r.cnt = '0;
      next_r.run = 1'b1;
      next_r.done = 1'b0;
    end else if (r.run && tick_i) begin
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt == W'(LEN - 1)) begin
        next_r.run = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else if (en_i) begin
      r <= next_r;
    end
  end

  assign done_o = r.done;

endmodule

// ==== src/rsq_top.sv ====
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Hold execution until power-up timer, oscillator timer and reset pin allow.
// - Timers ignore the pin; pin release after expiry starts execution at once.
// - Every reset updates flags so firmware can tell its cause.
// - Power-on and brown-out load their own flag patterns; others touch only theirs.
// - Power-on: restart at 0000h, clear power-on flag, set timeout and powerdown.
// - Brown-out: clear brown-out and stack flags, set timeout and powerdown, restart.
// - Watchdog reset clears its flag and timeout bit, restarts at 0000h.
// - Pin reset clears the pin flag and restarts at 0000h.
// - Pin reset while running leaves timeout and powerdown unchanged.
// - Pin reset in sleep sets timeout and clears powerdown.
// - Reset instruction clears its flag, restarts, status bits unchanged.
// - Enabled stack overflow sets its flag and restarts at 0000h.
// - Enabled stack underflow sets its flag and restarts at 0000h.
// - Watchdog wake clears timeout and powerdown, continues at next instruction.
// - Interrupt wake sets timeout, clears powerdown, continues at next instruction.
// - Interrupt wake with interrupts enabled pushes return and vectors to 0004h.
// - Crystal modes count 1024 oscillations after power-up timer or wake.
// - Both brown-out detectors clear the brown-out flag.
module rsq_top
  import rsq_pkg::*;
#(
  parameter int POWERUP_TIMER_LEN = POWERUP_TIMER_COUNT,
  parameter int OST_LEN = OST_COUNT
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // Reset sources and configuration
  input wire rsq_src_t src_i,
  input wire rsq_cfg_t cfg_i,
  input wire logic brownout_ready_i,
  // Register bus
  input wire rsq_apb_req_t apb_i,
  output rsq_apb_rsp_t apb_o,
  // Core control, brown-out control and interrupt
  output rsq_core_t core_o,
  output logic sw_brownout_enable_o,
  output logic brownout_fast_start_o,
  output logic irq_o
);

  if (POWERUP_TIMER_LEN < 1 || POWERUP_TIMER_LEN > 65535 || OST_LEN < 1 || OST_LEN > 65535) begin : g_bad
    $error("rsq_top: timer length out of range");
  end

  typedef struct packed {
    rsq_state_t fsm;
    logic [7:0] power_control_flags;
    logic to;
    logic pd;
    logic sbor;
    logic fast;
    logic [7:0] istat;
    logic [7:0] imask;
    logic wake_pend;
    logic gie_pend;
    rsq_core_t core;
    logic [31:0] prdata;
    logic slverr;
  } rsq_regs_t;

  rsq_regs_t r;
  rsq_regs_t next_r;
  logic pw_start;
  logic os_start;
  logic pw_done;
  logic os_done;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == ADDR_BROWNOUT_CONTROL || a == ADDR_POWER_CONTROL_FLAGS || a == ADDR_STATUS ||
           a == ADDR_ISTAT || a == ADDR_IMASK;
  endfunction

  // Event decode
  logic hard;
  logic pin_hold;
  logic run;
  logic ev_pin;
  logic ev_wdt;
  logic ev_ri;
  logic ev_ovf;
  logic ev_unf;
  logic ev_wwake;
  logic ev_iwake;
  logic ev_rst;
  logic ap_setup;
  logic ap_wr;
  logic ap_rd;
  logic [7:0] ev_bits;

  assign hard = src_i.por | src_i.bor | src_i.low_power_brownout;
  assign pin_hold = cfg_i.pin_en & ~src_i.pin_n;
  assign run = r.fsm == S_RUN;
  assign ev_pin = run & pin_hold;
  assign ev_wdt = run & ~pin_hold & ~src_i.sleep & src_i.wdt;
  assign ev_ri = run & ~pin_hold & ~src_i.sleep & src_i.instr;
  assign ev_ovf = run & ~pin_hold & cfg_i.stk_err_en & src_i.stk_over;
  assign ev_unf = run & ~pin_hold & cfg_i.stk_err_en & src_i.stk_under;
  assign ev_wwake = run & ~pin_hold & src_i.sleep & src_i.wdt;
  assign ev_iwake = run & ~pin_hold & src_i.sleep & ~src_i.wdt & src_i.irq_wake;
  assign ev_rst = ev_wdt | ev_ri | ev_ovf | ev_unf;
  assign ap_setup = apb_i.psel & ~apb_i.penable;
  assign ap_wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign ap_rd = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
  assign ev_bits = {ev_ovf, ev_unf, ev_wwake | ev_iwake, ev_wdt, ev_pin, ev_ri,
                    src_i.por, src_i.bor | src_i.low_power_brownout};

  always_comb begin
    next_r = r;
    pw_start = 1'b0;
    os_start = 1'b0;
    next_r.core.pc_load = 1'b0;
    next_r.core.resume = 1'b0;
    next_r.core.push = 1'b0;

    // Read data registered in the setup phase, so the access phase needs no wait
    if (ap_setup) begin
      next_r.slverr = ~is_mapped(apb_i.paddr);
      case (apb_i.paddr)
        ADDR_BROWNOUT_CONTROL: next_r.prdata = {24'h0, r.sbor, r.fast, 5'h00, brownout_ready_i};
        ADDR_POWER_CONTROL_FLAGS: next_r.prdata = {24'h0, r.power_control_flags};
        ADDR_STATUS: next_r.prdata = {27'h0, r.to, r.pd, 3'h0};
        ADDR_ISTAT: next_r.prdata = {24'h0, r.istat};
        ADDR_IMASK: next_r.prdata = {24'h0, r.imask};
        default: next_r.prdata = 32'h0;
      endcase
    end
    if (ap_wr) begin
      case (apb_i.paddr)
        ADDR_BROWNOUT_CONTROL: begin
          next_r.sbor = apb_i.pwdata[BC_SBOR];
          next_r.fast = apb_i.pwdata[BC_FAST];
        end
        ADDR_POWER_CONTROL_FLAGS: next_r.power_control_flags = apb_i.pwdata[7:0] & POWER_CONTROL_FLAGS_WMASK;
        ADDR_IMASK: next_r.imask = apb_i.pwdata[7:0];
        default: ;
      endcase
    end
    if (ap_rd && apb_i.paddr == ADDR_ISTAT) begin
      next_r.istat = 8'h00;
    end
    // Set wins over the read clear
    next_r.istat = next_r.istat | ev_bits;

    // Flag updates come after the bus write so hardware wins
    if (ev_pin) begin
      next_r.power_control_flags[PC_PIN] = 1'b0;
      // Outside sleep the status bits are left alone
      if (src_i.sleep) begin
        next_r.to = 1'b1;
        next_r.pd = 1'b0;
      end
    end
    if (ev_wdt) begin
      next_r.power_control_flags[PC_WDT] = 1'b0;
      next_r.to = 1'b0;
    end
    if (ev_ri) begin
      next_r.power_control_flags[PC_INSTR] = 1'b0;
    end
    if (ev_ovf) begin
      next_r.power_control_flags[PC_OVF] = 1'b1;
    end
    if (ev_unf) begin
      next_r.power_control_flags[PC_UNF] = 1'b1;
    end
    if (ev_wwake) begin
      next_r.to = 1'b0;
      next_r.pd = 1'b0;
    end
    if (ev_iwake) begin
      next_r.to = 1'b1;
      next_r.pd = 1'b0;
    end

    case (r.fsm)
      S_HOLD: begin
        next_r.fsm = S_POWERUP_TIMER;
        pw_start = cfg_i.powerup_timer_en;
      end
      S_POWERUP_TIMER: begin
        if (!cfg_i.powerup_timer_en || pw_done) begin
          next_r.fsm = S_OST;
          os_start = cfg_i.ost_req;
        end
      end
      S_OST: begin
        // Pin level is not looked at until both timers are through
        if (!cfg_i.ost_req || os_done) begin
          if (r.wake_pend) begin
            next_r.fsm = S_RUN;
            next_r.wake_pend = 1'b0;
            next_r.core.resume = 1'b1;
            next_r.core.push = r.gie_pend;
            next_r.core.pc_load = r.gie_pend;
            next_r.core.vec = VEC_IRQ;
          end else if (pin_hold) begin
            next_r.fsm = S_PINW;
          end else begin
            next_r.fsm = S_RUN;
            next_r.core.pc_load = 1'b1;
            next_r.core.vec = VEC_RESET;
          end
        end
      end
      S_PINW: begin
        if (!pin_hold) begin
          next_r.fsm = S_RUN;
          next_r.core.pc_load = 1'b1;
          next_r.core.vec = VEC_RESET;
        end
      end
      S_RUN: begin
        if (ev_pin) begin
          next_r.fsm = S_PINW;
        end else if (ev_rst) begin
          next_r.core.pc_load = 1'b1;
          next_r.core.vec = VEC_RESET;
        end else if (ev_wwake || ev_iwake) begin
          if (cfg_i.ost_req) begin
            // Crystal restarts on wake, so hold the core through the timer
            next_r.fsm = S_OST;
            os_start = 1'b1;
            next_r.wake_pend = 1'b1;
            next_r.gie_pend = ev_iwake & cfg_i.global_irq_enable;
          end else begin
            next_r.core.resume = 1'b1;
            next_r.core.push = ev_iwake & cfg_i.global_irq_enable;
            next_r.core.pc_load = ev_iwake & cfg_i.global_irq_enable;
            next_r.core.vec = VEC_IRQ;
          end
        end
      end
      default: next_r.fsm = S_HOLD;
    endcase

    if (hard) begin
      next_r.fsm = S_HOLD;
      pw_start = 1'b0;
      os_start = 1'b0;
      next_r.wake_pend = 1'b0;
      next_r.core.pc_load = 1'b0;
      next_r.core.resume = 1'b0;
      next_r.core.push = 1'b0;
      next_r.core.vec = VEC_RESET;
      next_r.to = 1'b1;
      next_r.pd = 1'b1;
      next_r.sbor = SBOR_RST;
      next_r.fast = FAST_RST;
      if (src_i.por) begin
        next_r.power_control_flags = POWER_CONTROL_FLAGS_POR_VAL;
      end else begin
        next_r.power_control_flags = (r.power_control_flags & POWER_CONTROL_FLAGS_BOR_KEEP) | POWER_CONTROL_FLAGS_BOR_SET;
      end
    end
    // Core held in any state but run, and pulsed for in-run resets
    next_r.core.crst = (next_r.fsm != S_RUN) | (run & ~hard & ev_rst);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.fsm <= S_HOLD;
      r.power_control_flags <= POWER_CONTROL_FLAGS_POR_VAL;
      r.to <= 1'b1;
      r.pd <= 1'b1;
      r.sbor <= SBOR_RST;
      r.fast <= FAST_RST;
      r.imask <= IMASK_RST;
      r.core.crst <= 1'b1;
      r.core.vec <= VEC_RESET;
    end else if (en_i) begin
      r <= next_r;
    end
  end

  rsq_timer #(.W(16), .LEN(POWERUP_TIMER_LEN)) u_powerup_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .start_i(pw_start),
    .tick_i(1'b1),
    .done_o(pw_done)
  );

  // Counts oscillator edges, not system clocks
  rsq_timer #(.W(16), .LEN(OST_LEN)) u_ost (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .start_i(os_start),
    .tick_i(src_i.osc_tick),
    .done_o(os_done)
  );

  assign apb_o.prdata = r.prdata;
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = r.slverr;
  assign core_o = r.core;
  assign sw_brownout_enable_o = r.sbor;
  assign brownout_fast_start_o = r.fast;
  assign irq_o = |(r.istat & r.imask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_powerup_timer_gate;
    en_i && !hard && r.fsm == S_POWERUP_TIMER && cfg_i.powerup_timer_en && !pw_done |=> r.fsm == S_POWERUP_TIMER;
  endproperty
  a_powerup_timer_gate: assert property (p_powerup_timer_gate) else $error("left power-up wait early");

  property p_pin_go;
    en_i && !hard && r.fsm == S_PINW && !pin_hold
      |=> r.fsm == S_RUN && core_o.pc_load && core_o.vec == VEC_RESET && !core_o.crst;
  endproperty
  a_pin_go: assert property (p_pin_go) else $error("pin release did not start core");

  property p_por;
    en_i && src_i.por |=> r.power_control_flags == POWER_CONTROL_FLAGS_POR_VAL && r.to && r.pd && core_o.crst;
  endproperty
  a_por: assert property (p_por) else $error("power-on flags wrong");

  property p_bor;
    en_i && !src_i.por && src_i.low_power_brownout
      |=> !r.power_control_flags[PC_BOR] && r.power_control_flags[7:6] == 2'b00 && r.power_control_flags[PC_POR] == $past(r.power_control_flags[PC_POR]);
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out flags wrong");

  property p_wdt;
    en_i && !hard && ev_wdt |=> !r.power_control_flags[PC_WDT] && !r.to && core_o.crst ##1 !core_o.crst;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset handling wrong");

  property p_pin_run;
    en_i && !hard && ev_pin && !src_i.sleep
      |=> !r.power_control_flags[PC_PIN] && r.to == $past(r.to) && r.pd == $past(r.pd);
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("pin reset touched status");

  property p_pin_sleep;
    en_i && !hard && ev_pin && src_i.sleep |=> r.to && !r.pd && r.fsm == S_PINW;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset in sleep wrong");

  property p_stack;
    en_i && !hard && ev_ovf |=> r.power_control_flags[PC_OVF] && core_o.pc_load && core_o.vec == VEC_RESET;
  endproperty
  a_stack: assert property (p_stack) else $error("stack overflow not flagged");

  property p_wake;
    en_i && !hard && ev_wwake && !cfg_i.ost_req |=> !r.to && !r.pd && core_o.resume;
  endproperty
  a_wake: assert property (p_wake) else $error("watchdog wake wrong");

  property p_irq_vec;
    core_o.push |-> core_o.pc_load && core_o.vec == VEC_IRQ && core_o.resume;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong");

endmodule

// ==== verification/rsq_core_model.sv ====
`timescale 1ns/1ps
// Core stand-in: follows the sequencer's hold, restart and wake commands
module rsq_core_model
  import rsq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Commands from the sequencer
  input wire rsq_core_t core_i,
  // Program counter as the core sees it
  output logic [15:0] pc_o
);
  // A load in the same cycle as hold wins, as an in-run restart pulses both
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pc_o <= 16'h0000;
    end else if (core_i.pc_load) begin
      pc_o <= core_i.vec;
    end else if (!core_i.crst) begin
      pc_o <= pc_o + 16'h0001;
    end
  end
endmodule

// ==== verification/test_reset_startup_and_cause_flags.sv ====
`timescale 1ns/1ps
module test_reset_startup_and_cause_flags;
  import rsq_pkg::*;
  localparam int PW = 4;
  localparam int OS = 3;
  localparam logic [10:0] M_POR = 11'h400, M_BOR = 11'h200, M_LP = 11'h100, M_WDT = 11'h040;
  localparam logic [10:0] M_IRQ = 11'h020, M_INS = 11'h010, M_OVF = 11'h008, M_UNF = 11'h004;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic en_i = 1'b1;
  logic rdy = 1'b1;
  logic tick = 1'b0;
  logic tick_on = 1'b0;
  logic err;
  logic sbor;
  logic fast;
  logic irq;
  logic [31:0] rd;
  logic [15:0] pc;
  rsq_src_t src = rsq_src_t'(11'h080);
  rsq_src_t src_w;
  rsq_cfg_t cfg = '0;
  rsq_apb_req_t apb = '0;
  rsq_apb_rsp_t rsp;
  rsq_core_t core;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n = 0;

  always #12.5 clk_i = ~clk_i;
  // Ticks every other clock so the start-up count is visible in time
  always @(posedge clk_i) tick <= tick_on & ~tick;
  always_comb begin
    src_w = src;
    src_w.osc_tick = tick;
  end

  rsq_top #(.POWERUP_TIMER_LEN(PW), .OST_LEN(OS)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .src_i(src_w), .cfg_i(cfg),
    .brownout_ready_i(rdy), .apb_i(apb), .apb_o(rsp), .core_o(core),
    .sw_brownout_enable_o(sbor), .brownout_fast_start_o(fast), .irq_o(irq)
  );
  rsq_core_model core_m (.clk_i(clk_i), .rstn_i(rstn_i), .core_i(core), .pc_o(pc));

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen; a hang is cut by the cycle ceiling
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do @(posedge clk_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [10:0] m);
    @(posedge clk_i);
    src <= rsq_src_t'(src | m);
    @(posedge clk_i);
    src <= rsq_src_t'(src & ~m);
  endtask

  task automatic wait_load(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (core.pc_load !== 1'b1 && n < lim);
  endtask

  task automatic restart(input logic [10:0] m, input logic [7:0] pf, input logic [7:0] st);
    xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    pulse(m);
    wait_load(10);
    chk(core.pc_load, 1'b1);
    chk(core.vec, VEC_RESET);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, {24'h0, pf});
    rd_chk(ADDR_STATUS, {24'h0, st});
  endtask

  task automatic wake(input logic [10:0] m, input logic [2:0] exp);
    @(posedge clk_i);
    src.sleep <= 1'b1;
    pulse(m);
    @(posedge clk_i);
    chk({core.resume, core.push, core.pc_load}, exp);
    src.sleep <= 1'b0;
  endtask

  task automatic test_regs();
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1d);
    rd_chk(ADDR_STATUS, 32'h18);
    rd_chk(ADDR_BROWNOUT_CONTROL, 32'h81);
    rdy <= 1'b0;
    rd_chk(ADDR_IMASK, 32'h0);
    rd_chk(ADDR_BROWNOUT_CONTROL, 32'h80);
    xfer(1'b1, ADDR_STATUS, 32'h0);
    rd_chk(ADDR_STATUS, 32'h18);
    xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'hff);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'hdf);
    xfer(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    xfer(1'b1, ADDR_BROWNOUT_CONTROL, 32'h40);
    // The write lands on the access edge and its outputs change on that edge; the check comes one edge later
    @(posedge clk_i);
    chk({sbor, fast}, 2'b01);
  endtask

  task automatic test_por();
    cfg <= '{pin_en: 1'b1, powerup_timer_en: 1'b1, ost_req: 1'b1, stk_err_en: 1'b1, global_irq_enable: 1'b1};
    src.pin_n <= 1'b0;
    tick_on <= 1'b1;
    pulse(M_POR);
    repeat (40) begin
      @(posedge clk_i);
      chk(core.crst, 1'b1);
    end
    src.pin_n <= 1'b1;
    wait_load(5);
    chk(n, 2);
    chk({core.crst, core.vec}, {1'b0, VEC_RESET});
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1d);
    rd_chk(ADDR_STATUS, 32'h18);
    pulse(M_POR);
    wait_load(60);
    chk(n >= PW + 2 * OS - 2, 1'b1);
    chk(n <= PW + 2 * OS + 6, 1'b1);
    cfg.powerup_timer_en <= 1'b0;
    cfg.ost_req <= 1'b0;
    pulse(M_POR);
    wait_load(10);
    chk(n, 4);
  endtask

  task automatic test_inrun();
    restart(M_INS, 8'h1b, 8'h18);
    restart(M_OVF, 8'h9f, 8'h18);
    restart(M_UNF, 8'h5f, 8'h18);
    restart(M_WDT, 8'h0f, 8'h08);
    xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    src.pin_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(core.crst, 1'b1);
    src.pin_n <= 1'b1;
    wait_load(5);
    chk(core.vec, VEC_RESET);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h17);
    rd_chk(ADDR_STATUS, 32'h08);
    cfg.stk_err_en <= 1'b0;
    xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    pulse(M_OVF);
    wait_load(8);
    chk(core.pc_load, 1'b0);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    cfg.stk_err_en <= 1'b1;
  endtask

  task automatic test_wake();
    wake(M_IRQ, 3'b111);
    chk(core.vec, VEC_IRQ);
    @(posedge clk_i);
    chk(pc, VEC_IRQ);
    rd_chk(ADDR_STATUS, 32'h10);
    xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    wake(M_WDT, 3'b100);
    rd_chk(ADDR_STATUS, 32'h00);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1f);
    src.sleep <= 1'b1;
    src.pin_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    src.pin_n <= 1'b1;
    wait_load(5);
    chk(core.vec, VEC_RESET);
    src.sleep <= 1'b0;
    rd_chk(ADDR_STATUS, 32'h10);
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h17);
  endtask

  task automatic test_bor();
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'hff);
      pulse(i == 0 ? M_BOR : M_LP);
      wait_load(20);
      chk(core.vec, VEC_RESET);
      rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1e);
      rd_chk(ADDR_STATUS, 32'h18);
    end
  endtask

  task automatic test_irq();
    xfer(1'b0, ADDR_ISTAT, 32'h0);
    pulse(M_WDT);
    wait_load(5);
    chk(irq, 1'b0);
    xfer(1'b1, ADDR_IMASK, 32'h10);
    @(posedge clk_i);
    chk(irq, 1'b1);
    xfer(1'b0, ADDR_ISTAT, 32'h0);
    chk(rd & 32'h10, 32'h10);
    @(posedge clk_i);
    chk(irq, 1'b0);
  endtask

  // Firmware write lands on the same edge as the hardware flag update
  task automatic test_race();
    fork
      xfer(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h1f);
      begin
        repeat (2) @(posedge clk_i);
        src.instr <= 1'b1;
        @(posedge clk_i);
        src.instr <= 1'b0;
      end
    join
    rd_chk(ADDR_POWER_CONTROL_FLAGS, 32'h1b);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    test_regs();
    test_por();
    test_inrun();
    test_wake();
    test_bor();
    test_irq();
    test_race();
    report_and_stop();
  end
endmodule
